//--- src/ptp_mem.sv
// Step program memory with registered read data
module ptp_mem
   import ptp_pkg::*;
#(
   parameter int unsigned AW = 12,
   parameter int unsigned DW = 32
) (
   input  wire logic          pclk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // ptp_mem

//--- src/ptp_pins.sv
// Pin mode mapping for one channel pair
module ptp_pins
   import ptp_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [1:0] mode,
   input  wire logic       run,
   input  wire logic       tick,
   input  wire logic       dir_up,
   input  wire logic [1:0] gpo,
   output logic            pin_even,
   output logic            pin_odd
);
   // ****************************************
   // Quadrature phase: two bits, one quarter per tick
   // ****************************************
   logic [1:0] ph_q;
   logic [1:0] ph_d;
   logic       e_d;
   logic       o_d;
   logic       lvl;

   assign ph_d = (run && tick) ? (dir_up ? ph_q + 2'h1 : ph_q - 2'h1) : ph_q;
   assign lvl  = ph_q[0];

   always_comb begin
      e_d = 1'b0;
      o_d = 1'b0;
      case (mode)
         MD_GPO: begin
            e_d = gpo[0];
            o_d = gpo[1];
         end
         MD_UD: begin
            e_d = run && dir_up && lvl;
            o_d = run && !dir_up && lvl;
         end
         MD_PD: begin
            e_d = run && lvl;
            o_d = dir_up;
         end
         MD_AB: begin
            e_d = ph_q[1] ^ ph_q[0];
            o_d = ph_q[1];
         end
         default: begin
            e_d = 1'b0;
            o_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_q     <= 2'h0;
         pin_even <= 1'b0;
         pin_odd  <= 1'b0;
      end else begin
         ph_q     <= ph_d;
         pin_even <= e_d;
         pin_odd  <= o_d;
      end
   end
endmodule // ptp_pins

//--- src/ptp_pkg.sv
// Package: register map, field layout, modes and states of the pulse train positioner
package ptp_pkg;
   localparam int unsigned NUM_CH     = 4;
   localparam int unsigned MAX_STEPS  = 250;
   localparam int unsigned STEP_WORDS = 9;
   localparam int unsigned STEP_AW    = 8;
   localparam int unsigned MEM_DEPTH  = 256;

   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [11:0] OFS_CTRL    = 12'h000;
   localparam logic [11:0] OFS_MODE    = 12'h004;
   localparam logic [11:0] OFS_GPO     = 12'h008;
   localparam logic [11:0] OFS_STAT    = 12'h00C;
   localparam logic [11:0] OFS_IRQST   = 12'h010;
   localparam logic [11:0] OFS_IRQMSK  = 12'h014;
   localparam logic [11:0] OFS_ERRCODE = 12'h018;
   localparam logic [11:0] OFS_NSTEPS  = 12'h01C;
   localparam logic [11:0] OFS_PADDR   = 12'h020;
   localparam logic [11:0] OFS_PDATA   = 12'h024;
   localparam logic [11:0] OFS_STEPIDX = 12'h028;

   // ****************************************
   // Fields
   // ****************************************
   localparam int unsigned CTRL_EN  = 0;
   localparam int unsigned CTRL_PAU = 1;
   localparam int unsigned CTRL_ABT = 2;
   localparam int unsigned CTRL_CH  = 4;
   localparam int unsigned STAT_ACT = 0;
   localparam int unsigned STAT_ERR = 1;
   localparam int unsigned STAT_DN  = 2;
   localparam int unsigned STAT_OWN = 3;
   localparam int unsigned STAT_RDY = 4;
   localparam int unsigned IRQ_DN   = 0;
   localparam int unsigned IRQ_ERR  = 1;

   // Step words: 0 half period (cycles), 1 distance (pulses), 2 bit0 direction
   localparam logic [3:0] W_HALF = 4'h0;
   localparam logic [3:0] W_DIST = 4'h1;
   localparam logic [3:0] W_DIR  = 4'h2;

   localparam logic [7:0]  ERR_NONE   = 8'h00;
   localparam logic [7:0]  ERR_EMPTY  = 8'h01;
   localparam logic [7:0]  ERR_ZEROHP = 8'h02;
   localparam logic [7:0]  ERR_NOMODE = 8'h03;
   localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      MD_GPO = 2'h0,
      MD_UD  = 2'h1,
      MD_PD  = 2'h2,
      MD_AB  = 2'h3
   } ptp_mode_t;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_WAIT  = 6'b000010,
      ST_FETCH = 6'b000100,
      ST_LOAD  = 6'b001000,
      ST_RUN   = 6'b010000,
      ST_PAUSE = 6'b100000
   } ptp_state_t;
endpackage : ptp_pkg

//--- src/ptp_top.sv
// Top: APB slave, step sequencer and four pulse channels
//
// Operation
// - Program holds up to 250 nine-word steps
// - Enable rise on free channel runs next
// - After last step, wrap to first
// - Per-channel ready flag shows free channel
// - Busy channel: wait until owner releases
// - Enable low stops pulses at once
// - Pause suspends output, keeps remaining distance
// - Pause release resumes remaining pulses
// - Abort stops pulses at once
// - After abort, next enable starts step one
// - Transmitting indication on while pulsing
// - Error sets indication and error code
// - Done indication on each step completion
// - Without mode, pins are general outputs
// - Up/down: even up pulses, odd down
// - Two-phase: even phase A, odd B
module ptp_top
   import ptp_pkg::*;
#(
   parameter int unsigned STEPS = MAX_STEPS
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   irq,
   output logic      [NUM_CH-1:0] ready_flag,
   output logic      [NUM_CH-1:0] pin_even,
   output logic      [NUM_CH-1:0] pin_odd
);
   initial begin
      if (STEPS < 1 || STEPS > MAX_STEPS) begin
         $error("STEPS out of range");
      end
   end

   localparam int unsigned PAW = 12;
   localparam logic [PAW-1:0] WORDS9 = PAW'(STEP_WORDS);

   function automatic logic [PAW-1:0] word_addr(input logic [STEP_AW-1:0] s, input logic [3:0] w);
      word_addr = PAW'(s) * WORDS9 + PAW'(w);
   endfunction

   // ****************************************
   // APB decode
   // ****************************************
   logic [31:0] ctrl_q;
   logic [31:0] mode_q;
   logic [31:0] gpo_q;
   logic [1:0]  irqst_q;
   logic [1:0]  irqmsk_q;
   logic [7:0]  err_q;
   logic [7:0]  nsteps_q;
   logic [PAW-1:0] paddr_q;
   logic [31:0] rd_mux;
   logic        known;
   logic        acc;
   logic        wr;

   // Only the edge that shows pready takes the access, so PDATA moves the pointer once
   assign acc = psel && penable && pready;
   assign wr  = acc && pwrite;
   assign known = (paddr == OFS_CTRL) || (paddr == OFS_MODE) || (paddr == OFS_GPO) || (paddr == OFS_STAT)
               || (paddr == OFS_IRQST) || (paddr == OFS_IRQMSK) || (paddr == OFS_ERRCODE)
               || (paddr == OFS_NSTEPS) || (paddr == OFS_PADDR) || (paddr == OFS_PDATA)
               || (paddr == OFS_STEPIDX);
   logic [31:0] mem_rdata;
   logic        mem_we;
   logic [PAW-1:0] mem_raddr;

   assign mem_we = wr && (paddr == OFS_PDATA) && (paddr_q < PAW'(STEPS * STEP_WORDS));

   // ****************************************
   // Sequencer (one shared program, one engine)
   // ****************************************
   ptp_state_t  st_q, st_d;
   logic [1:0]  ch_q;
   logic [STEP_AW-1:0] step_q;
   logic [3:0]  fw_q;
   logic [31:0] half_q;
   logic [31:0] cnt_q;
   logic [31:0] left_q;
   logic        dir_q;
   logic        en_q;
   logic        act_q;
   logic        dn_q;
   logic        errf_q;
   logic        tick;
   logic        en;
   logic        pause_input;
   logic        abort_input;
   logic        en_rise;
   logic [1:0]  sel_ch;
   logic        ch_free;
   logic        other_busy;
   logic [NUM_CH-1:0] ext_busy;
   logic        step_end;
   logic [STEP_AW-1:0] next_step;
   logic [1:0]  ch_mode;

   assign en      = ctrl_q[CTRL_EN];
   assign pause_input     = ctrl_q[CTRL_PAU];
   assign abort_input     = ctrl_q[CTRL_ABT];
   assign sel_ch  = ctrl_q[CTRL_CH +: 2];
   assign en_rise = en && !en_q;
   // Other owners come from software through GPO upper bits
   assign ext_busy   = gpo_q[8 +: NUM_CH];
   assign other_busy = ext_busy[sel_ch];
   assign ch_free    = !other_busy;
   assign ch_mode    = mode_q[2*sel_ch +: 2];
   assign tick       = (st_q == ST_RUN) && (cnt_q == 32'h0);
   assign step_end   = tick && (left_q == 32'h1) && fw_q[0];
   assign next_step  = (step_q + 8'h1 >= nsteps_q) ? 8'h0 : step_q + 8'h1;
   assign mem_raddr  = (st_q == ST_FETCH) ? word_addr(step_q, fw_q) : paddr_q;

   ptp_mem #(.AW(PAW), .DW(32)) u_mem (
      .pclk  (pclk),
      .we    (mem_we),
      .waddr (paddr_q),
      .wdata (pwdata),
      .raddr (mem_raddr),
      .rdata (mem_rdata)
   );

   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE:  st_d = en_rise ? (ch_free ? ST_FETCH : ST_WAIT) : ST_IDLE;
         ST_WAIT:  st_d = !en ? ST_IDLE : (ch_free ? ST_FETCH : ST_WAIT);
         ST_FETCH: st_d = (fw_q == W_DIR + 4'h1) ? ST_LOAD : ST_FETCH;
         ST_LOAD:  st_d = ST_RUN;
         ST_RUN:   st_d = step_end ? ST_IDLE : (pause_input ? ST_PAUSE : ST_RUN);
         ST_PAUSE: st_d = pause_input ? ST_PAUSE : ST_RUN;
         default:  st_d = ST_IDLE;
      endcase
      if (abort_input || !en || errf_q) begin
         st_d = (st_q == ST_IDLE) ? ST_IDLE : ST_IDLE;
      end
   end

   logic error_now;
   logic [7:0] err_code;
   assign error_now = (st_q == ST_LOAD) && ((nsteps_q == 8'h0) || (half_q == 32'h0) || (left_q == 32'h0)
                      || (ch_mode == MD_GPO));
   assign err_code  = (nsteps_q == 8'h0) ? ERR_EMPTY : ((ch_mode == MD_GPO) ? ERR_NOMODE : ERR_ZEROHP);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q   <= ST_IDLE;
         ch_q   <= 2'h0;
         step_q <= 8'h0;
         fw_q   <= 4'h0;
         half_q <= RESET_ZERO;
         cnt_q  <= RESET_ZERO;
         left_q <= RESET_ZERO;
         dir_q  <= 1'b1;
         en_q   <= 1'b0;
         errf_q <= 1'b0;
      end else begin
         st_q   <= error_now ? ST_IDLE : st_d;
         en_q   <= en;
         errf_q <= 1'b0;
         if (st_q == ST_IDLE && st_d != ST_IDLE) begin
            ch_q <= sel_ch;
            fw_q <= 4'h0;
         end
         if (st_q == ST_WAIT) begin
            fw_q <= 4'h0;
         end
         if (abort_input) begin
            step_q <= 8'h0;
         end
         if (st_q == ST_FETCH) begin
            fw_q <= fw_q + 4'h1;
            if (fw_q == W_HALF + 4'h1) begin
               half_q <= mem_rdata;
            end
            if (fw_q == W_DIR) begin
               left_q <= mem_rdata;
            end
            if (fw_q == W_DIR + 4'h1) begin
               dir_q <= mem_rdata[0];
            end
         end
         if (st_q == ST_LOAD) begin
            cnt_q <= half_q - 32'h1;
         end
         if (st_q == ST_RUN) begin
            cnt_q <= tick ? half_q - 32'h1 : cnt_q - 32'h1;
            fw_q  <= tick ? fw_q + 4'h1 : fw_q;
            if (tick && fw_q[0]) begin
               left_q <= left_q - 32'h1;
            end
         end
         if (step_end && !abort_input) begin
            step_q <= next_step;
         end
      end
   end

   // ****************************************
   // Indications and interrupts
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_q <= 1'b0;
         dn_q  <= 1'b0;
         err_q <= ERR_NONE;
      end else begin
         act_q <= (st_d == ST_RUN) && !abort_input && en && !error_now;
         dn_q  <= step_end ? 1'b1 : (en_rise ? 1'b0 : dn_q);
         if (error_now) begin
            err_q <= err_code;
         end else if (en_rise) begin
            err_q <= ERR_NONE;
         end
      end
   end

   // Set wins over write-one-to-clear
   logic [1:0] ev;
   assign ev = {error_now, step_end};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q   <= RESET_ZERO;
         mode_q   <= RESET_ZERO;
         gpo_q    <= RESET_ZERO;
         irqst_q  <= 2'h0;
         irqmsk_q <= 2'h0;
         nsteps_q <= 8'h0;
         paddr_q  <= '0;
      end else begin
         irqst_q <= ev | (irqst_q & ~((wr && paddr == OFS_IRQST) ? pwdata[1:0] : 2'h0));
         if (wr && paddr == OFS_CTRL)   ctrl_q   <= pwdata;
         if (wr && paddr == OFS_MODE)   mode_q   <= pwdata;
         if (wr && paddr == OFS_GPO)    gpo_q    <= pwdata;
         if (wr && paddr == OFS_IRQMSK) irqmsk_q <= pwdata[1:0];
         if (wr && paddr == OFS_NSTEPS) begin
            nsteps_q <= (pwdata[7:0] > 8'(STEPS)) ? 8'(STEPS) : pwdata[7:0];
         end
         if (wr && paddr == OFS_PADDR)  paddr_q  <= pwdata[PAW-1:0];
         if (acc && paddr == OFS_PDATA) paddr_q  <= paddr_q + 12'h1;
      end
   end

   logic [NUM_CH-1:0] own;
   assign own = (st_q != ST_IDLE && st_q != ST_WAIT) ? (NUM_CH'(1) << ch_q) : '0;

   always_comb begin
      rd_mux = RESET_ZERO;
      case (paddr)
         OFS_CTRL:    rd_mux = ctrl_q;
         OFS_MODE:    rd_mux = mode_q;
         OFS_GPO:     rd_mux = gpo_q;
         OFS_STAT:    rd_mux = {24'h0, ready_flag, 1'b0, dn_q, err_q != ERR_NONE, act_q};
         OFS_IRQST:   rd_mux = {30'h0, irqst_q};
         OFS_IRQMSK:  rd_mux = {30'h0, irqmsk_q};
         OFS_ERRCODE: rd_mux = {24'h0, err_q};
         OFS_NSTEPS:  rd_mux = {24'h0, nsteps_q};
         OFS_PADDR:   rd_mux = {20'h0, paddr_q};
         OFS_PDATA:   rd_mux = mem_rdata;
         OFS_STEPIDX: rd_mux = {24'h0, step_q};
         default:     rd_mux = RESET_ZERO;
      endcase
   end

   // Two-cycle access so the memory read settles before data are taken
   logic wait_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata     <= RESET_ZERO;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         wait_q     <= 1'b0;
         irq        <= 1'b0;
         ready_flag <= {NUM_CH{1'b1}};
      end else begin
         wait_q     <= psel && !penable;
         pready     <= psel && !pready && (wait_q || penable);
         prdata     <= rd_mux;
         pslverr    <= psel && !known;
         irq        <= |(irqst_q & irqmsk_q);
         ready_flag <= ~(own | ext_busy);
      end
   end

   // ****************************************
   // Pin drivers
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         ptp_pins u_pins (
            .pclk     (pclk),
            .presetn  (presetn),
            .mode     (mode_q[2*g +: 2]),
            .run      ((st_q == ST_RUN) && (ch_q == 2'(g)) && en && !abort_input),
            .tick     (tick),
            .dir_up   (dir_q),
            .gpo      (gpo_q[2*g +: 2]),
            .pin_even (pin_even[g]),
            .pin_odd  (pin_odd[g])
         );
      end
   endgenerate
endmodule // ptp_top

//--- tb/ptp_motor.sv
// Far-side model: motor driver counting steps of channel 0
module ptp_motor
   import ptp_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [1:0] mode,
   input  wire logic       pin_a,
   input  wire logic       pin_b,
   output int              pos
);
   timeunit 1ns;
   timeprecision 1ns;
   logic a_q;
   logic b_q;
   wire  a_rise = pin_a & ~a_q;
   wire  b_rise = pin_b & ~b_q;

   // Direction taken at the step edge, as a real driver latches it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_q <= 1'b0;
         b_q <= 1'b0;
         pos <= 0;
      end else begin
         a_q <= pin_a;
         b_q <= pin_b;
         case (mode)
            MD_UD: pos <= pos + int'(a_rise) - int'(b_rise);
            MD_PD: if (a_rise) pos <= pin_b ? pos + 1 : pos - 1;
            // Each phase A edge is one pulse; A unlike B after the edge means A leads
            MD_AB: if (pin_a != a_q) pos <= (pin_a != pin_b) ? pos + 1 : pos - 1;
            default: ;
         endcase
      end
   end
endmodule // ptp_motor

//--- tb/ptp_top_sva.sv
// Checker: port-level properties of the pulse train positioner
module ptp_top_sva
   import ptp_pkg::*;
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [11:0]       paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic              irq,
   input wire logic [NUM_CH-1:0] ready_flag,
   input wire logic [NUM_CH-1:0] pin_even,
   input wire logic [NUM_CH-1:0] pin_odd
);
   timeunit 1ns;
   timeprecision 1ns;
   // Shadows of settings; age hides the pin latency after a write
   logic [31:0] ctrl_q, mode_q, gpo_q, mask_q;
   logic [2:0]  age_q;
   wire         wr_hit = psel & penable & pwrite & pready;
   wire         cfg_wr = wr_hit & (paddr inside {OFS_CTRL, OFS_MODE, OFS_GPO, OFS_IRQMSK});
   wire [2:0]   age_d  = cfg_wr ? 3'h0 : (age_q == 3'h7 ? age_q : age_q + 3'h1);
   wire         calm   = age_q >= 3'h5;
   wire [1:0]   md0    = mode_q[1:0];
   wire         pulsed = calm & (md0 != MD_GPO);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= RESET_ZERO;
         mode_q <= RESET_ZERO;
         gpo_q  <= RESET_ZERO;
         mask_q <= RESET_ZERO;
         age_q  <= 3'h7;
      end else begin
         if (wr_hit && paddr == OFS_CTRL) ctrl_q <= pwdata;
         if (wr_hit && paddr == OFS_MODE) mode_q <= pwdata;
         if (wr_hit && paddr == OFS_GPO) gpo_q <= pwdata;
         if (wr_hit && paddr == OFS_IRQMSK) mask_q <= pwdata;
         age_q <= age_d;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   gpo_pins_a: assert property (calm && md0 == MD_GPO |->
      pin_even[0] == gpo_q[0] && pin_odd[0] == gpo_q[1]) else $error("gpo pins differ");
   updown_excl_a: assert property (calm && md0 == MD_UD |-> !(pin_even[0] && pin_odd[0]))
      else $error("both count pins high");
   quad_gray_a: assert property (calm && md0 == MD_AB |->
      !($changed(pin_even[0]) && $changed(pin_odd[0]))) else $error("both phases moved");
   en_low_a: assert property (pulsed && !ctrl_q[CTRL_EN] |-> $stable(pin_even[0]) && $stable(pin_odd[0]))
      else $error("pins move with enable low");
   pause_hold_a: assert property (pulsed && ctrl_q[CTRL_PAU] && ctrl_q[CTRL_EN] |-> $stable(pin_even[0]))
      else $error("pins move in pause");
   abort_stop_a: assert property (pulsed && ctrl_q[CTRL_ABT] |-> $stable(pin_even[0]) [*2])
      else $error("pins move in abort");
   ready_free_a: assert property (calm && !ctrl_q[CTRL_EN] && !gpo_q[8] |-> ready_flag[0])
      else $error("free channel not ready");
   irq_mask_a: assert property (calm && mask_q[1:0] == 2'h0 |-> !irq)
      else $error("masked interrupt raised");

   cover property (md0 == MD_AB && $rose(pin_odd[0]));
   cover property (pulsed && ctrl_q[CTRL_PAU]);
   cover property ($rose(irq));
endmodule // ptp_top_sva

bind ptp_top ptp_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .irq(irq), .ready_flag(ready_flag), .pin_even(pin_even),
   .pin_odd(pin_odd));

//--- tb/test_ptp_top.sv
// Testbench: register-level tests of the pulse train positioner
module test_ptp_top;
   import ptp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic        pready, pslverr, irq;
   logic [3:0]  ready_flag, pin_even, pin_odd;
   logic [1:0]  md = 2'h0;
   int          fail_count = 0, comparisons = 0, pos;
   int          hp[3] = '{2, 3, 2};
   int          dd[3] = '{5, -3, 24};

   always #20 pclk = ~pclk;

   ptp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .ready_flag(ready_flag),
      .pin_even(pin_even), .pin_odd(pin_odd));
   ptp_motor motor (.pclk(pclk), .presetn(presetn), .mode(md), .pin_a(pin_even[0]), .pin_b(pin_odd[0]), .pos(pos));

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         $display("Error at %0t: got %h, expected %h", $time, g, e);
         fail_count++;
      end
   endtask

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Starts just after an edge; idle edge at the end avoids double drive
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      chk(32'(n < 20), 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic waitbit(input int b);
      int n;
      n = 0;
      do begin
         apb(1'b0, OFS_STAT, 32'h0);
         n++;
      end while (r[b] !== 1'b1 && n < 300);
      chk(32'(r[b]), 32'h1);
   endtask

   task automatic abort_input;
      wr(OFS_CTRL, 32'h4);
      repeat (8) @(posedge pclk);
      wr(OFS_CTRL, 32'h0);
   endtask

   // k: 0 plain, 1 pause and resume, 2 channel held elsewhere, 3 enable dropped
   task automatic go(input int s, input int k);
      int p0, p;
      p0 = pos;
      if (k == 2) wr(OFS_GPO, 32'h100);
      wr(OFS_CTRL, 32'h1);
      if (k > 0) begin
         repeat (12) @(posedge pclk);
         if (k != 2) wr(OFS_CTRL, k == 1 ? 32'h3 : 32'h0);
         repeat (4) @(posedge pclk);
         p = pos;
         repeat (30) @(posedge pclk);
         chk(pos, p);
         if (k == 3) return;
         wr(k == 1 ? OFS_CTRL : OFS_GPO, k == 1 ? 32'h1 : 32'h0);
      end
      waitbit(STAT_DN);
      chk(pos - p0, dd[s]);
      chk(32'(irq), 32'h1);
      wr(OFS_IRQST, 32'h3);
      wr(OFS_CTRL, 32'h0);
   endtask

   initial begin
      repeat (40000) @(posedge pclk);
      fail_count++;
      end_sim();
   end

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(32'(ready_flag), 32'hF);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(r, 32'hF0);
      apb(1'b0, 12'h0FC, 32'h0);
      chk({r[31:1], pslverr}, 32'h1);
      $display("Test reset finished");
      wr(OFS_IRQMSK, 32'h3);
      md = MD_PD;
      wr(OFS_MODE, 32'h2);
      wr(OFS_CTRL, 32'h1);
      waitbit(STAT_ERR);
      apb(1'b0, OFS_ERRCODE, 32'h0);
      chk(r, 32'(ERR_EMPTY));
      chk(32'(irq), 32'h1);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_IRQST, 32'h3);
      @(posedge pclk);
      chk(32'(irq), 32'h0);
      $display("Test error finished");
      wr(OFS_NSTEPS, 32'h3);
      wr(OFS_PADDR, 32'h0);
      for (int s = 0; s < 3; s++) begin
         for (int w = 0; w < 9; w++) begin
            wr(OFS_PDATA, 32'(w == 0 ? hp[s] : w == 1 ? (dd[s] < 0 ? -dd[s] : dd[s]) : w == 2 ? int'(dd[s] > 0) : 0));
         end
      end
      for (int m = 1; m < 4; m++) begin
         md = 2'(m);
         wr(OFS_MODE, 32'(m));
         abort_input();
         go(0, 0);
         go(1, 0);
         go(2, 0);
         go(0, 0);
      end
      $display("Test modes finished");
      abort_input();
      go(0, 0);
      go(1, 0);
      go(2, 1);
      go(0, 3);
      abort_input();
      go(0, 0);
      go(1, 2);
      $display("Test control finished");
      md = MD_GPO;
      wr(OFS_MODE, 32'h0);
      for (int g = 1; g < 3; g++) begin
         wr(OFS_GPO, 32'(g));
         repeat (2) @(posedge pclk);
         chk(32'({pin_odd[0], pin_even[0]}), 32'(g));
      end
      $display("Test gpo finished");
      end_sim();
   end
endmodule // test_ptp_top
